// file: shared/fswc_pkg.sv
// Purpose: Shared constants and types of the flash self-write controller
// Assumes: 32-bit AXI4-Lite register bus, 10 ns core clock
// Notes:   Register map, control bit layout, protection decode, state types
package fswc_pkg;
    localparam int FSWC_AXI_AW   = 8;
    localparam int FSWC_DATA_W   = 14;
    localparam int FSWC_ADDR_W   = 15;
    localparam int FSWC_LATCH_AW = 4;
    localparam int FSWC_TMR_W    = 24;
    localparam int FSWC_CLK_NS   = 10;

    localparam logic [7:0] FSWC_OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] FSWC_OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] FSWC_OFS_DATA_LOW  = 8'h08;
    localparam logic [7:0] FSWC_OFS_DATA_HIGH = 8'h0C;
    localparam logic [7:0] FSWC_OFS_CONTROL   = 8'h10;
    localparam logic [7:0] FSWC_OFS_UNLOCK    = 8'h14;
    localparam logic [7:0] FSWC_OFS_CFG_TWO   = 8'h18;
    localparam logic [7:0] FSWC_OFS_CFG_ONE   = 8'h1C;
    localparam logic [7:0] FSWC_OFS_IRQ_STAT  = 8'h20;
    localparam logic [7:0] FSWC_OFS_IRQ_EN    = 8'h24;
    localparam logic [7:0] FSWC_OFS_IRQ_CLR   = 8'h28;

    localparam int FSWC_CTL_READ   = 0;
    localparam int FSWC_CTL_WRITE  = 1;
    localparam int FSWC_CTL_ENABLE = 2;
    localparam int FSWC_CTL_ERROR  = 3;
    localparam int FSWC_CTL_ERASE  = 4;
    localparam int FSWC_CTL_LATCH  = 5;
    localparam int FSWC_CFG_PROT_BIT = 7;

    localparam int FSWC_IRQ_W      = 3;
    localparam int FSWC_IRQ_DONE   = 0;
    localparam int FSWC_IRQ_ABORT  = 1;
    localparam int FSWC_IRQ_DENIED = 2;

    localparam logic [7:0]  FSWC_KEY_FIRST  = 8'h55;
    localparam logic [7:0]  FSWC_KEY_SECOND = 8'hAA;
    localparam logic [1:0]  FSWC_WP_NONE    = 2'h3;
    localparam logic [1:0]  FSWC_WP_LOW     = 2'h2;
    localparam logic [1:0]  FSWC_WP_HALF    = 2'h1;
    localparam logic [14:0] FSWC_LIM_LOW    = 15'h00FF;
    localparam logic [14:0] FSWC_LIM_HALF   = 15'h01FF;
    localparam logic [14:0] FSWC_LIM_ALL    = 15'h03FF;
    localparam logic [13:0] FSWC_ERASED     = 14'h3FFF;
    localparam logic [11:0] FSWC_CFG2_ONES  = 12'hFFF;
    localparam logic [1:0]  FSWC_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  FSWC_RESP_SLVERR = 2'h2;

    localparam logic [1:0] FSWC_EXT_READ  = 2'h0;
    localparam logic [1:0] FSWC_EXT_WRITE = 2'h1;
    localparam logic [1:0] FSWC_EXT_BULK  = 2'h2;
    localparam logic [1:0] FSWC_EXT_CFG   = 2'h3;

    typedef enum logic [1:0] {FU_LOCKED, FU_HALF, FU_ARMED} fswc_unlock_t;
    typedef enum logic [1:0] {FS_IDLE, FS_LATCH, FS_PROG, FS_ERASE}
        fswc_state_t;

    typedef struct packed {
        logic [6:0]            flash_addr_high;
        logic [7:0]            flash_addr_low;
        logic [5:0]            flash_data_high;
        logic [7:0]            flash_data_low;
        logic                  start_read;
        logic                  start_write;
        logic                  write_enable_bit;
        logic                  write_error_flag;
        logic                  row_erase;
        logic                  latch_only;
        fswc_unlock_t          unlock;
        fswc_state_t           st;
        logic [FSWC_TMR_W-1:0] timer;
        logic [FSWC_IRQ_W-1:0] irq_stat;
        logic [FSWC_IRQ_W-1:0] irq_en;
        logic                  aw_full;
        logic                  w_full;
        logic [7:0]            aw_addr;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  ext_s1;
        logic                  ext_s2;
        logic                  ext_ack;
        logic [13:0]           ext_rdata;
    } fswc_regs_t;

    function automatic logic fswc_protected(input logic [1:0] wp,
                                            input logic [14:0] a);
        case (wp)
            FSWC_WP_NONE: return 1'b0;
            FSWC_WP_LOW:  return a <= FSWC_LIM_LOW;
            FSWC_WP_HALF: return a <= FSWC_LIM_HALF;
            default:      return a <= FSWC_LIM_ALL;
        endcase
    endfunction : fswc_protected
endpackage : fswc_pkg

// file: src/fswc_top.sv
// Purpose: Flash self-read/self-write controller with AXI4-Lite registers
// Assumes: aresetn and por_n synchronous, active low; ext_op, ext_addr and
//          ext_wdata held stable while ext_req is high
// Notes:   Flash array and configuration are flip-flops, not reset by aresetn
// Summary of operation
// - Program reads and writes flash through registers
// - Data pair carries the 14-bit flash word
// - Address pair carries 15-bit word address
// - High register holds address MSB, low LSB
// - Internal timer sets write and erase duration
// - Start bits set-only, cleared by hardware
// - Writes need enable bit, cleared at power-up
// - Device reset during a program or erase sets error flag
// - Unlock register reads as all zeros
// - Code protect blocks external programmer only
// - Only external bulk erase or power-on reset removes code protect
// - Write protect blocks self-write in chosen range
// - Protect field decodes 11/10/01/00 ranges
// - Protect field bits 1:0, rest reads one
// - Rows are the smallest self-erase unit
// - Hidden write latches filled through data pair
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module fswc_top
    import fswc_pkg::*;
#(
    parameter int MEM_DEPTH    = 1024,
    parameter int PROG_TIME_NS = 2000000
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   por_n,
    input  wire logic                   ce,
    input  wire logic [FSWC_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output      logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output      logic                   s_axi_wready,
    output      logic [1:0]             s_axi_bresp,
    output      logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [FSWC_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output      logic                   s_axi_arready,
    output      logic [31:0]            s_axi_rdata,
    output      logic [1:0]             s_axi_rresp,
    output      logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   ext_req,
    input  wire logic [1:0]             ext_op,
    input  wire logic [FSWC_ADDR_W-1:0] ext_addr,
    input  wire logic [FSWC_DATA_W-1:0] ext_wdata,
    output      logic                   ext_ack,
    output      logic [FSWC_DATA_W-1:0] ext_rdata,
    output      logic                   irq
);
    localparam int MEM_AW   = $clog2(MEM_DEPTH);
    localparam int ROW_LEN  = 2 ** FSWC_LATCH_AW;
    localparam int PROG_CYC = (PROG_TIME_NS + FSWC_CLK_NS - 1) / FSWC_CLK_NS;
    localparam logic [FSWC_TMR_W-1:0] TMR_LOAD = FSWC_TMR_W'(PROG_CYC - 1);

    fswc_regs_t             q;
    fswc_regs_t             next_q;
    logic [FSWC_DATA_W-1:0] mem        [MEM_DEPTH];
    logic [FSWC_DATA_W-1:0] next_mem   [MEM_DEPTH];
    logic [FSWC_DATA_W-1:0] latch      [ROW_LEN];
    logic [FSWC_DATA_W-1:0] next_latch [ROW_LEN];
    logic [1:0]             self_write_protect_field;
    logic [1:0]             next_wp;
    logic                   code_protect_bit;
    logic                   next_prot;
    logic [FSWC_ADDR_W-1:0] full_addr;
    logic [FSWC_DATA_W-1:0] full_data;
    logic [MEM_AW-1:0]      row_base;
    logic [7:0]             wd;
    logic [FSWC_IRQ_W-1:0]  ev;
    logic [FSWC_IRQ_W-1:0]  clr;
    logic [FSWC_DATA_W-1:0] cfg_one;

    function automatic logic [MEM_AW-1:0] word_index(
        input logic [FSWC_ADDR_W-1:0] a);
        return a[MEM_AW-1:0];
    endfunction : word_index

    assign s_axi_awready = ce & ~q.aw_full & ~q.bvalid;
    assign s_axi_wready  = ce & ~q.w_full & ~q.bvalid;
    assign s_axi_arready = ce & ~q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign ext_ack       = q.ext_ack;
    assign ext_rdata     = q.ext_rdata;
    assign irq           = |(q.irq_stat & q.irq_en);

    always_comb begin
        next_q     = q;
        next_mem   = mem;
        next_latch = latch;
        next_wp    = self_write_protect_field;
        next_prot  = code_protect_bit;
        ev         = '0;
        clr        = '0;
        full_addr  = {q.flash_addr_high, q.flash_addr_low};
        full_data  = {q.flash_data_high, q.flash_data_low};
        row_base   = word_index({full_addr[FSWC_ADDR_W-1:FSWC_LATCH_AW],
                                 {FSWC_LATCH_AW{1'b0}}});
        wd         = q.w_data[7:0];
        cfg_one    = FSWC_ERASED;
        cfg_one[FSWC_CFG_PROT_BIT] = code_protect_bit;

        // Self-read takes one cycle and lands in the data pair
        if (q.start_read) begin
            {next_q.flash_data_high, next_q.flash_data_low} =
                mem[word_index(full_addr)];
            next_q.start_read = 1'b0;
            ev[FSWC_IRQ_DONE] = 1'b1;
        end

        case (q.st)
            FS_LATCH: begin
                next_latch[full_addr[FSWC_LATCH_AW-1:0]] = full_data;
                next_q.start_write = 1'b0;
                next_q.st          = FS_IDLE;
                ev[FSWC_IRQ_DONE]  = 1'b1;
            end
            FS_PROG, FS_ERASE: begin
                if (q.timer == '0) begin
                    for (int i = 0; i < ROW_LEN; i++) begin
                        // Whole row at once: erase granularity is a row
                        next_mem[row_base + MEM_AW'(i)] =
                            (q.st == FS_ERASE) ? FSWC_ERASED : latch[i];
                        if (q.st == FS_PROG) begin
                            next_latch[i] = FSWC_ERASED;
                        end
                    end
                    next_q.start_write = 1'b0;
                    next_q.st          = FS_IDLE;
                    ev[FSWC_IRQ_DONE]  = 1'b1;
                end else begin
                    next_q.timer = q.timer - 1'b1;
                end
            end
            default: ;
        endcase

        // External programmer: four-phase req/ack, served only when idle
        next_q.ext_s1 = ext_req;
        next_q.ext_s2 = q.ext_s1;
        if (!q.ext_s2) begin
            next_q.ext_ack = 1'b0;
        end else if (!q.ext_ack && q.st == FS_IDLE && !q.start_write) begin
            next_q.ext_ack = 1'b1;
            case (ext_op)
                FSWC_EXT_READ: begin
                    if (code_protect_bit) begin
                        next_q.ext_rdata = mem[word_index(ext_addr)];
                    end else begin
                        next_q.ext_rdata    = '0;
                        ev[FSWC_IRQ_DENIED] = 1'b1;
                    end
                end
                FSWC_EXT_WRITE: begin
                    // Write protect field is not consulted here
                    if (code_protect_bit) begin
                        next_mem[word_index(ext_addr)] = ext_wdata;
                    end else begin
                        ev[FSWC_IRQ_DENIED] = 1'b1;
                    end
                end
                FSWC_EXT_BULK: begin
                    for (int i = 0; i < MEM_DEPTH; i++) begin
                        next_mem[i] = FSWC_ERASED;
                    end
                    for (int i = 0; i < ROW_LEN; i++) begin
                        next_latch[i] = FSWC_ERASED;
                    end
                    next_wp   = FSWC_WP_NONE;
                    next_prot = 1'b1;
                end
                default: begin
                    next_wp   = ext_wdata[1:0];
                    // Code protection can be armed here but never released
                    next_prot = code_protect_bit &
                                ext_wdata[FSWC_CFG_PROT_BIT];
                end
            endcase
        end

        if (s_axi_awvalid && s_axi_awready) begin
            next_q.aw_full = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_q.w_full = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            next_q.bvalid = 1'b0;
        end

        if (q.aw_full && q.w_full && !q.bvalid) begin
            next_q.aw_full = 1'b0;
            next_q.w_full  = 1'b0;
            next_q.bvalid  = 1'b1;
            next_q.bresp   = FSWC_RESP_OKAY;
            case ({q.aw_addr[7:2], 2'b00})
                FSWC_OFS_ADDR_LOW: begin
                    if (q.w_strb[0] && !q.start_write) begin
                        next_q.flash_addr_low = wd;
                    end
                end
                FSWC_OFS_ADDR_HIGH: begin
                    if (q.w_strb[0] && !q.start_write) begin
                        next_q.flash_addr_high = wd[6:0];
                    end
                end
                FSWC_OFS_DATA_LOW: begin
                    if (q.w_strb[0] && !q.start_write) begin
                        next_q.flash_data_low = wd;
                    end
                end
                FSWC_OFS_DATA_HIGH: begin
                    if (q.w_strb[0] && !q.start_write) begin
                        next_q.flash_data_high = wd[5:0];
                    end
                end
                FSWC_OFS_CONTROL: begin
                    if (q.w_strb[0]) begin
                        // Zero writes never clear the start bits
                        next_q.start_read = next_q.start_read |
                                            wd[FSWC_CTL_READ];
                        next_q.write_enable_bit = wd[FSWC_CTL_ENABLE];
                        if (!wd[FSWC_CTL_ERROR]) begin
                            next_q.write_error_flag = 1'b0;
                        end
                        if (q.st == FS_IDLE && !q.start_write) begin
                            next_q.row_erase  = wd[FSWC_CTL_ERASE];
                            next_q.latch_only = wd[FSWC_CTL_LATCH];
                            if (wd[FSWC_CTL_WRITE] && wd[FSWC_CTL_ENABLE]) begin
                                next_q.unlock = FU_LOCKED;
                                if (q.unlock != FU_ARMED ||
                                    fswc_protected(self_write_protect_field,
                                                   full_addr)) begin
                                    ev[FSWC_IRQ_ABORT] = 1'b1;
                                end else begin
                                    next_q.start_write = 1'b1;
                                    next_q.timer       = TMR_LOAD;
                                    if (wd[FSWC_CTL_ERASE]) begin
                                        next_q.st = FS_ERASE;
                                    end else if (wd[FSWC_CTL_LATCH]) begin
                                        next_q.st = FS_LATCH;
                                    end else begin
                                        next_q.st = FS_PROG;
                                    end
                                end
                            end
                        end
                    end
                end
                FSWC_OFS_UNLOCK: begin
                    if (q.w_strb[0]) begin
                        if (wd == FSWC_KEY_SECOND && q.unlock == FU_HALF) begin
                            next_q.unlock = FU_ARMED;
                        end else if (wd == FSWC_KEY_FIRST) begin
                            next_q.unlock = FU_HALF;
                        end else begin
                            next_q.unlock = FU_LOCKED;
                        end
                    end
                end
                FSWC_OFS_CFG_TWO, FSWC_OFS_CFG_ONE, FSWC_OFS_IRQ_STAT: ;
                FSWC_OFS_IRQ_EN: begin
                    if (q.w_strb[0]) begin
                        next_q.irq_en = wd[FSWC_IRQ_W-1:0];
                    end
                end
                FSWC_OFS_IRQ_CLR: begin
                    if (q.w_strb[0]) begin
                        clr = wd[FSWC_IRQ_W-1:0];
                    end
                end
                default: next_q.bresp = FSWC_RESP_SLVERR;
            endcase
        end

        // A new event beats a clear in the same cycle
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;

        if (q.rvalid && s_axi_rready) begin
            next_q.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_q.rvalid = 1'b1;
            next_q.rresp  = FSWC_RESP_OKAY;
            next_q.rdata  = '0;
            case ({s_axi_araddr[7:2], 2'b00})
                FSWC_OFS_ADDR_LOW:  next_q.rdata[7:0] = q.flash_addr_low;
                FSWC_OFS_ADDR_HIGH: next_q.rdata[6:0] = q.flash_addr_high;
                FSWC_OFS_DATA_LOW:  next_q.rdata[7:0] = q.flash_data_low;
                FSWC_OFS_DATA_HIGH: next_q.rdata[5:0] = q.flash_data_high;
                FSWC_OFS_CONTROL: begin
                    next_q.rdata[FSWC_CTL_READ]   = q.start_read;
                    next_q.rdata[FSWC_CTL_WRITE]  = q.start_write;
                    next_q.rdata[FSWC_CTL_ENABLE] = q.write_enable_bit;
                    next_q.rdata[FSWC_CTL_ERROR]  = q.write_error_flag;
                    next_q.rdata[FSWC_CTL_ERASE]  = q.row_erase;
                    next_q.rdata[FSWC_CTL_LATCH]  = q.latch_only;
                end
                FSWC_OFS_UNLOCK: next_q.rdata = '0;
                FSWC_OFS_CFG_TWO: begin
                    next_q.rdata[FSWC_DATA_W-1:0] =
                        {FSWC_CFG2_ONES, self_write_protect_field};
                end
                FSWC_OFS_CFG_ONE:  next_q.rdata[FSWC_DATA_W-1:0] = cfg_one;
                FSWC_OFS_IRQ_STAT: next_q.rdata[FSWC_IRQ_W-1:0] = q.irq_stat;
                FSWC_OFS_IRQ_EN:   next_q.rdata[FSWC_IRQ_W-1:0] = q.irq_en;
                FSWC_OFS_IRQ_CLR:  ;
                default: next_q.rresp = FSWC_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!por_n) begin
            q        <= '0;
            q.st     <= FS_IDLE;
            q.unlock <= FU_LOCKED;
        end else if (!aresetn) begin
            q        <= '0;
            q.st     <= FS_IDLE;
            q.unlock <= FU_LOCKED;
            // Error flag survives device reset so software can see it
            q.write_error_flag <= q.write_error_flag |
                                  (q.st == FS_PROG) |
                                  (q.st == FS_ERASE);
        end else if (ce) begin
            q <= next_q;
        end
    end

    // Array and configuration model nonvolatile storage: no device reset
    always_ff @(posedge aclk) begin
        if (ce && aresetn && por_n) begin
            mem <= next_mem;
        end
        if (!por_n || !aresetn) begin
            latch <= '{default: FSWC_ERASED};
        end else if (ce) begin
            latch <= next_latch;
        end
        if (!por_n) begin
            self_write_protect_field <= FSWC_WP_NONE;
            code_protect_bit         <= 1'b1;
        end else if (ce && aresetn) begin
            self_write_protect_field <= next_wp;
            code_protect_bit         <= next_prot;
        end
    end
endmodule : fswc_top

// file: verification/fswc_checker.sv
// Purpose: Bus timing checks on the flash controller
// Assumes: ce high while checked
// Notes:   Bound to every fswc_top
`timescale 1ns/10ps
module fswc_checker
    import fswc_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       por_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] s_axi_araddr,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_n);
    wire ar_take = s_axi_arvalid && s_axi_arready;
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no bvalid");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_write_single: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_read_answer: assert property (ar_take
        |=> s_axi_rvalid) else $error("no rvalid");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_read_single: assert property (s_axi_rvalid
        |-> !s_axi_arready) else $error("read overlap");
    a_unlock_zero: assert property (ar_take &&
        s_axi_araddr == FSWC_OFS_UNLOCK |=> s_axi_rdata == 32'h0)
        else $error("unlock readable");
    a_cfg_ones: assert property (ar_take &&
        s_axi_araddr == FSWC_OFS_CFG_TWO |=> s_axi_rdata[13:2] == FSWC_CFG2_ONES)
        else $error("config fill wrong");
endmodule : fswc_checker
bind fswc_top fswc_checker u_chk (.*);

// file: verification/fswc_core_model.sv
// Purpose: Core model issuing register bus cycles
// Assumes: one transfer at a time
// Notes:   Released payloads show inverted values
`timescale 1ns/10ps
module fswc_core_model
    import fswc_pkg::*;
(
    input  wire logic        aclk,
    output      logic [7:0]  s_axi_awaddr,
    output      logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output      logic [31:0] s_axi_wdata,
    output      logic [3:0]  s_axi_wstrb,
    output      logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    output      logic        s_axi_bready,
    output      logic [7:0]  s_axi_araddr,
    output      logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output      logic        s_axi_rready
);
    assign s_axi_wstrb = 4'hF;
    initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
             s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    // Ready is sampled at the falling edge, so the take is the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta = 1'b0, tw = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta |= s_axi_awready;
            tw |= s_axi_wready;
            @(posedge aclk);
            if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        do @(negedge aclk); while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic unl;
        wr(FSWC_OFS_UNLOCK, {24'h0, FSWC_KEY_FIRST});
        wr(FSWC_OFS_UNLOCK, {24'h0, FSWC_KEY_SECOND});
    endtask : unl
    task automatic adr(input logic [14:0] a);
        wr(FSWC_OFS_ADDR_HIGH, {25'h0, a[14:8]});
        wr(FSWC_OFS_ADDR_LOW, {24'h0, a[7:0]});
    endtask : adr
endmodule : fswc_core_model

// file: verification/fswc_top_tb.sv
// Purpose: Self-checking bench of the flash controller
// Assumes: short program time of 10 cycles
// Notes:   Scenarios run in order and share flash state
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_mismatch++; $display("mismatch %s exp %h got %h", n, e, g); end end
module fswc_top_tb
    import fswc_pkg::*;
;
    logic        aclk, aresetn, por_n, ce, ext_req, ext_ack, irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [1:0]  ext_op, s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [14:0] ext_addr;
    logic [13:0] ext_wdata, ext_rdata;
    int          n_mismatch, checks_done;
    fswc_top #(.PROG_TIME_NS(100)) u_dut (.*);
    fswc_core_model u_core (.*);
    task automatic cr(string n, logic [7:0] a, logic [31:0] e);
        u_core.rd(a, d, r);
        `CHK(n, e, d)
    endtask : cr
    task automatic ci(logic [7:0] a, logic [31:0] v, logic e);
        u_core.wr(a, v);
        @(negedge aclk);
        `CHK("irq", e, irq)
    endtask : ci
    task automatic ext(logic [1:0] op, logic [14:0] a, logic [13:0] w);
        @(posedge aclk);
        {ext_op, ext_addr, ext_wdata, ext_req} <= {op, a, w, 1'b1};
        do @(negedge aclk); while (!ext_ack);
        @(posedge aclk);
        ext_req <= 1'b0;
        do @(negedge aclk); while (ext_ack);
    endtask : ext
    task automatic results;
        if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic t_regs;
        cr("cfg2", FSWC_OFS_CFG_TWO, 32'h3FFF);
        u_core.wr(FSWC_OFS_UNLOCK, 32'h55);
        cr("unlock", FSWC_OFS_UNLOCK, 32'h0);
        u_core.rd(8'h40, d, r);
        `CHK("resp", FSWC_RESP_SLVERR, r)
    endtask : t_regs
    task automatic t_locked;
        u_core.adr(15'h0300);
        ci(FSWC_OFS_CONTROL, 32'h6, 1'b0);
        cr("ctl", FSWC_OFS_CONTROL, 32'h4);
        ci(FSWC_OFS_IRQ_EN, 32'h2, 1'b1);
        ci(FSWC_OFS_IRQ_CLR, 32'h2, 1'b0);
    endtask : t_locked
    task automatic t_prog;
        u_core.wr(FSWC_OFS_DATA_HIGH, 32'h12);
        u_core.wr(FSWC_OFS_DATA_LOW, 32'h34);
        u_core.unl();
        u_core.wr(FSWC_OFS_CONTROL, 32'h26);
        u_core.unl();
        u_core.wr(FSWC_OFS_CONTROL, 32'h6);
        cr("busy", FSWC_OFS_CONTROL, 32'h6);
        repeat (12) @(posedge aclk);
        cr("done", FSWC_OFS_CONTROL, 32'h4);
        u_core.wr(FSWC_OFS_DATA_LOW, 32'h0);
        u_core.wr(FSWC_OFS_CONTROL, 32'h1);
        cr("rd", FSWC_OFS_CONTROL, 32'h0);
        cr("dlo", FSWC_OFS_DATA_LOW, 32'h34);
        cr("dhi", FSWC_OFS_DATA_HIGH, 32'h12);
    endtask : t_prog
    task automatic t_reset;
        u_core.unl();
        u_core.wr(FSWC_OFS_CONTROL, 32'h2);
        u_core.wr(FSWC_OFS_CONTROL, 32'h16);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        cr("err", FSWC_OFS_CONTROL, 32'h8);
    endtask : t_reset
    task automatic t_ext;
        ext(FSWC_EXT_CFG, 15'h0, 14'h0002);
        cr("wp", FSWC_OFS_CFG_TWO, 32'h3FFE);
        u_core.adr(15'h00FF);
        u_core.unl();
        u_core.wr(FSWC_OFS_CONTROL, 32'h6);
        cr("prot", FSWC_OFS_CONTROL, 32'h4);
        ext(FSWC_EXT_READ, 15'h0300, 14'h0);
        `CHK("ext", 14'h0, ext_rdata)
        ext(FSWC_EXT_BULK, 15'h0, 14'h0);
        cr("cp", FSWC_OFS_CFG_ONE, 32'h3FFF);
    endtask : t_ext
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        {aresetn, por_n, ce, ext_req, ext_op, ext_addr, ext_wdata} = {3'h1, 32'h0};
        repeat (5) @(posedge aclk);
        {aresetn, por_n} <= 2'h3;
        t_regs();
        t_locked();
        t_prog();
        t_reset();
        t_ext();
        results();
    end
    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        results();
    end
endmodule : fswc_top_tb
